/* emic_consts.vh */
// Constants of the external memory interface controller: offsets, fields, resets, memory map.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef EMIC_CONSTS_VH
`define EMIC_CONSTS_VH

// ==========================================
// Register byte offsets on the Avalon-MM slave
`define EMIC_OFF_CTRL_A 4'h0
`define EMIC_OFF_CTRL_B 4'h4
`define EMIC_OFF_STATUS 4'h8
`define EMIC_ADDR_W 4

// ==========================================
// Reset values
`define EMIC_CTRL_A_RST 8'h00
`define EMIC_CTRL_B_RST 8'h00

// ==========================================
// Control A fields
`define EMIC_A_ENABLE 7
`define EMIC_A_LIMIT_HI 6
`define EMIC_A_LIMIT_LO 4
`define EMIC_A_UWAIT_HI 3
`define EMIC_A_UWAIT_LO 2
`define EMIC_A_LWAIT_HI 1
`define EMIC_A_LWAIT_LO 0

// ==========================================
// Control B fields
`define EMIC_B_KEEPER 7
`define EMIC_B_MASK_HI 2
`define EMIC_B_MASK_LO 0
`define EMIC_B_WMASK 8'h87

// ==========================================
// Memory map defaults
`define EMIC_ISRAM_END 16'h10FF
`define EMIC_SECTOR_SIZE_LOG2 13

`endif

/* emic_wait_sel.v */
// Sector decode and wait-state selection for one external access.
// Assumes a registered control A value and an address stable while it is used.
`timescale 1ns/10ps

module emic_wait_sel (
  input wire [15:0] addr,
  input wire [2:0] sector_limit,
  input wire [1:0] upper_wait,
  input wire [1:0] lower_wait,
  output reg in_upper,
  output reg [1:0] strobe_extra,
  output reg addr_hold
);
`include "emic_consts.vh"

  reg [1:0] code;

  // ==========================================
  // Sector choice and wait decode
  always @* begin
    if (sector_limit == 3'h0) begin
      in_upper = 1'b1;
    end else begin
      in_upper = (addr[15:`EMIC_SECTOR_SIZE_LOG2] >= sector_limit);
    end
    code = in_upper ? upper_wait : lower_wait;
    strobe_extra = (code == 2'h3) ? 2'h2 : code;
    addr_hold = (code == 2'h3);
  end

endmodule

/* emic_ctrl.v */
// External parallel memory interface: control registers, address map and bus cycle sequencer.
// Assumes one clock clk_sys, asynchronous reset rst, a CPU-side request port held until done,
// and Avalon-MM register access with waitrequest.
//
// Functional notes
// - Enable switches pins to memory functions
// - Enabled overrides port direction except on released high lines; disabled restores
// - Disabled: no aliasing above internal SRAM
// - Limit zero: one sector, upper waits
// - Limit k: upper from k*0x2000
// - Upper sector uses bits 3..2
// - Lower sector uses bits 1..0
// - Wait codes: 0,1,2, 2 plus address hold
// - Keeper holds last level when tri-stated
// - Keeper works even when interface disabled
// - Reserved control B bits read zero
// - Mask code sets driven high address bits
// - Internal range never starts external cycle
// - Released pins output port values
// - Internal access: no read/write strobes
// - Valid low address at latch falling edge
`timescale 1ns/10ps
`include "emic_consts.vh"

module emic_ctrl #(
  parameter [15:0] ISRAM_END = `EMIC_ISRAM_END
) (
  input wire clk_sys,
  input wire rst,
  // Avalon-MM register slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  // CPU data-space request
  input wire cpu_req,
  input wire cpu_we,
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  output reg cpu_done,
  output reg [7:0] cpu_rdata,
  output reg cpu_internal,
  // General-purpose port state for the shared pins
  input wire [7:0] port_ad_out,
  input wire [7:0] port_ad_dir,
  input wire [7:0] port_hi_out,
  input wire [7:0] port_hi_dir,
  input wire port_ale_out,
  input wire port_ale_dir,
  input wire port_rd_out,
  input wire port_rd_dir,
  input wire port_wr_out,
  input wire port_wr_dir,
  // Pins: multiplexed address/data, high address, strobes
  input wire [7:0] muxed_addr_data_bus_in,
  output reg [7:0] muxed_addr_data_bus_out,
  output reg [7:0] muxed_addr_data_bus_oe_n,
  output reg [7:0] high_address_bus_out,
  output reg [7:0] high_address_bus_oe_n,
  output reg ale_out,
  output reg ale_oe_n,
  output reg rd_n_out,
  output reg rd_oe_n,
  output reg wr_n_out,
  output reg wr_oe_n,
  output wire [7:0] keeper_level,
  output wire keeper_active
);

  // ==========================================
  // Access sequencer states, binary codes; unused codes fall back to idle
  // IDLE: waits for a request, captures address, data and wait code
  // ADDR: latch strobe high, low address byte on the bus
  // STROBE: first strobe cycle; write data driven, read bus released
  // WAIT: one cycle for each extra wait state
  // END: strobe released, write data held one more cycle
  // HOLD: spare cycle before the next address, wait code 3 only
  // INT: internal access; latch strobe may pulse, no read or write strobe
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [2:0] ST_END = 3'h4;
  localparam [2:0] ST_HOLD = 3'h5;
  localparam [2:0] ST_INT = 3'h6;

  // Control registers, captured request and pin drive state
  reg [7:0] ext_mem_control_a_q;
  reg [7:0] ext_mem_control_b_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] wait_cnt_q;
  reg hold_q;
  reg [15:0] addr_q;
  reg [7:0] wdata_q;
  reg we_q;
  reg [7:0] ad_q;
  reg ad_drive_q;
  reg ale_q;
  reg rd_q;
  reg wr_q;
  reg [7:0] keep_q;
  reg [7:0] hi_keep_mask;
  reg [7:0] ad_val;
  reg [7:0] ad_oe_n;
  // Decoded control fields and wait selection
  wire interface_enable;
  wire bus_keeper_enable;
  wire [2:0] high_mask;
  wire is_external;
  wire sel_upper;
  wire [1:0] sel_extra;
  wire sel_hold;
  wire [7:0] ad_pin;

  assign interface_enable = ext_mem_control_a_q[`EMIC_A_ENABLE];
  assign bus_keeper_enable = ext_mem_control_b_q[`EMIC_B_KEEPER];
  assign high_mask = ext_mem_control_b_q[`EMIC_B_MASK_HI:`EMIC_B_MASK_LO];

  // ==========================================
  // Register slave: zero-wait answers
  // Every register answers in the cycle of the request, so no wait states
  assign avs_waitrequest = 1'b0;

  // Register writes honour the low byte lane
  // Control A: bit 7 enable, 6..4 sector limit, 3..2 upper wait, 1..0 lower wait
  // Control B: bit 7 keeper, 6..3 always zero, 2..0 high address mask
  // A new sector limit or wait code applies from the next request; an access in flight
  // keeps the wait code it captured when it was taken
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_mem_control_a_q <= `EMIC_CTRL_A_RST;
      ext_mem_control_b_q <= `EMIC_CTRL_B_RST;
    end else if (avs_write && avs_byteenable[0]) begin
      if (avs_address == `EMIC_OFF_CTRL_A) begin
        ext_mem_control_a_q <= avs_writedata[7:0];
      end
      if (avs_address == `EMIC_OFF_CTRL_B) begin
        ext_mem_control_b_q <= avs_writedata[7:0] & `EMIC_B_WMASK;
      end
    end
  end

  // Read mux; unmapped addresses answer zero with a slave error
  // Reads have no side effects, so the mux is purely combinational
  // Status returns the level that the keeper remembers on the bus
  always @* begin
    avs_readdata = 32'h00000000;
    avs_response = 2'h0;
    case (avs_address)
      `EMIC_OFF_CTRL_A: avs_readdata = {24'h000000, ext_mem_control_a_q};
      `EMIC_OFF_CTRL_B: avs_readdata = {24'h000000, ext_mem_control_b_q};
      `EMIC_OFF_STATUS: avs_readdata = {24'h000000, keep_q};
      default: begin
        if (avs_read || avs_write) begin
          avs_response = 2'h2;
        end
      end
    endcase
  end

  // ==========================================
  // Address map: external only above internal range while enabled
  // With the interface off every address is internal: nothing above the
  // internal range folds back onto internal memory
  assign is_external = interface_enable && (cpu_addr > ISRAM_END);

  // Sector and wait decode: live address while idle, captured address after,
  // so a request that moves early cannot shift a running cycle to the other sector
  emic_wait_sel u_wait_sel (
    .addr(state_q == ST_IDLE ? cpu_addr : addr_q),
    .sector_limit(ext_mem_control_a_q[`EMIC_A_LIMIT_HI:`EMIC_A_LIMIT_LO]),
    .upper_wait(ext_mem_control_a_q[`EMIC_A_UWAIT_HI:`EMIC_A_UWAIT_LO]),
    .lower_wait(ext_mem_control_a_q[`EMIC_A_LWAIT_HI:`EMIC_A_LWAIT_LO]),
    .in_upper(sel_upper),
    .strobe_extra(sel_extra),
    .addr_hold(sel_hold)
  );

  // ==========================================
  // Sequencer next state
  // From the take edge E: strobe rises at E+1, stands 1+extra cycles and
  // falls with the done pulse at E+2+extra; code 3 adds a spare cycle
  // The done pulse blocks a second take in the cycle after it, which gives
  // the requester one edge to drop its request
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cpu_req && !cpu_done) begin
          state_d = is_external ? ST_ADDR : ST_INT;
        end
      end
      ST_ADDR: state_d = ST_STROBE;
      ST_STROBE: state_d = (wait_cnt_q == 2'h0) ? ST_END : ST_WAIT;
      ST_WAIT: state_d = (wait_cnt_q == 2'h1) ? ST_END : ST_WAIT;
      ST_END: state_d = hold_q ? ST_HOLD : ST_IDLE;
      ST_HOLD: state_d = ST_IDLE;
      ST_INT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Sequencer registers and pin drive
  // Every pin register changes on the clock, so the pads see no decode glitches
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      wait_cnt_q <= 2'h0;
      hold_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      ad_q <= 8'h00;
      ad_drive_q <= 1'b0;
      ale_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cpu_done <= 1'b0;
      cpu_rdata <= 8'h00;
      cpu_internal <= 1'b0;
    end else begin
      state_q <= state_d;
      cpu_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cpu_req && !cpu_done) begin
            addr_q <= cpu_addr;
            wdata_q <= cpu_wdata;
            we_q <= cpu_we;
            cpu_internal <= !is_external;
            wait_cnt_q <= sel_extra;
            hold_q <= sel_hold;
            ad_q <= cpu_addr[7:0];
            ad_drive_q <= interface_enable;
            ale_q <= interface_enable;
          end
        end
        ST_ADDR: begin
          // Latch strobe falls at the edge that puts write data on the bus or releases it
          ale_q <= 1'b0;
          ad_q <= we_q ? wdata_q : addr_q[7:0];
          ad_drive_q <= we_q;
          rd_q <= !we_q;
          wr_q <= we_q;
        end
        ST_STROBE, ST_WAIT: begin
          if (state_d == ST_WAIT && state_q == ST_WAIT) begin
            wait_cnt_q <= wait_cnt_q - 2'h1;
          end
          // Read data taken at the edge that ends the strobe
          if (state_d == ST_END) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cpu_rdata <= muxed_addr_data_bus_in;
            cpu_done <= 1'b1;
          end
        end
        // Write data held through this cycle for the memory's hold time
        ST_END: ad_drive_q <= 1'b0;
        ST_INT: begin
          ale_q <= 1'b0;
          ad_drive_q <= 1'b0;
          cpu_done <= 1'b1;
        end
        default: ale_q <= 1'b0;
      endcase
    end
  end

  // ==========================================
  // Bus keeper: remembers last pin level, independent of enable
  // Driven lines refresh it every cycle; with every line released the pin
  // reads back the keeper itself, so the level simply recirculates
  // The pad holds the line weakly from keeper_level while keeper_active is set
  assign ad_pin = ad_val & ~ad_oe_n;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keep_q <= 8'h00;
    end else begin
      keep_q <= (ad_oe_n == 8'hFF) ? muxed_addr_data_bus_in : ad_pin | (keep_q & ad_oe_n);
    end
  end
  assign keeper_active = bus_keeper_enable;
  assign keeper_level = keep_q;

  // ==========================================
  // Pin override: per-bit mask of driven high address lines
  // Code 0 keeps all eight lines, codes 1..6 give up the top lines one by one,
  // code 7 gives the whole byte back to the port
  // Released lines take value and direction from the port, so software can
  // force upper address bits to zero and reach the low external locations
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_hi
      always @* begin
        hi_keep_mask[gi] = (high_mask == 3'h0) ? 1'b1 :
                           (high_mask == 3'h7) ? 1'b0 :
                           (gi < (8 - high_mask));
      end
    end
  endgenerate

  // Output muxing of shared pins
  // Enabled: pins belong to the interface and the port direction is ignored, except on released high address lines
  // Disabled: every pin follows its port value and direction again
  always @* begin
    if (interface_enable) begin
      ad_val = ad_q;
      ad_oe_n = ad_drive_q ? 8'h00 : 8'hFF;
      muxed_addr_data_bus_out = ad_q;
      muxed_addr_data_bus_oe_n = ad_oe_n;
      high_address_bus_out = (addr_q[15:8] & hi_keep_mask) | (port_hi_out & ~hi_keep_mask);
      high_address_bus_oe_n = ~(hi_keep_mask | port_hi_dir);
      ale_out = ale_q;
      ale_oe_n = 1'b0;
      rd_n_out = ~rd_q;
      rd_oe_n = 1'b0;
      wr_n_out = ~wr_q;
      wr_oe_n = 1'b0;
    end else begin
      ad_val = port_ad_out;
      ad_oe_n = ~port_ad_dir;
      muxed_addr_data_bus_out = port_ad_out;
      muxed_addr_data_bus_oe_n = ~port_ad_dir;
      high_address_bus_out = port_hi_out;
      high_address_bus_oe_n = ~port_hi_dir;
      ale_out = port_ale_out;
      ale_oe_n = ~port_ale_dir;
      rd_n_out = port_rd_out;
      rd_oe_n = ~port_rd_dir;
      wr_n_out = port_wr_out;
      wr_oe_n = ~port_wr_dir;
    end
  end

endmodule

/* emic_ctrl_checker.sv */
// Port checker for the memory interface controller.
// Assumes a bind onto emic_ctrl; one clock, async reset.
`timescale 1ns/10ps
module emic_ctrl_checker #(
  parameter [15:0] ISRAM_END = 16'h10FF
) (
  input wire clk_sys,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  input wire cpu_req,
  input wire [15:0] cpu_addr,
  input wire cpu_done,
  input wire cpu_internal,
  input wire [7:0] muxed_addr_data_bus_out,
  input wire ale_out,
  input wire ale_oe_n,
  input wire rd_n_out,
  input wire rd_oe_n,
  input wire wr_n_out,
  input wire wr_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Driven and active strobe levels
  wire ale_act = !ale_oe_n && ale_out;
  wire rd_act = !rd_oe_n && !rd_n_out;
  wire wr_act = !wr_oe_n && !wr_n_out;
  wire stb_act = rd_act || wr_act;
  // ======
  // Register bus
  no_wait_a: assert property (!avs_waitrequest) else $error("waitrequest raised");
  read_zero_a: assert property (avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  unmapped_err_a: assert property (avs_read && avs_address == 4'hC |-> avs_response == 2'h2)
    else $error("no error on unmapped read");
  // ======
  // Bus cycles
  ale_pulse_a: assert property ($rose(ale_act) |=> !ale_act) else $error("latch strobe too long");
  addr_valid_a: assert property ($fell(ale_act) && stb_act |->
    $past(muxed_addr_data_bus_out) == $past(cpu_addr[7:0])) else $error("low address wrong");
  strobe_start_a: assert property ($fell(ale_act) && cpu_req && cpu_addr > ISRAM_END |-> stb_act)
    else $error("no strobe after latch");
  strobe_end_a: assert property ($fell(stb_act) |-> cpu_done) else $error("strobe end without done");
  quiet_int_a: assert property (cpu_done && cpu_internal |-> !$past(stb_act) && !stb_act)
    else $error("strobe on internal access");
  one_strobe_a: assert property (!(rd_act && wr_act)) else $error("both strobes active");
  done_pulse_a: assert property (cpu_done |=> !cpu_done) else $error("done too long");
  // Main scenarios
  ext_c: cover property ($fell(stb_act));
  int_c: cover property (cpu_done && cpu_internal);
  bad_c: cover property (avs_read && avs_address == 4'hC);
endmodule

/* emic_sram_model.sv */
// Behavioural byte-wide SRAM behind an address latch taken on the clock.
// Assumes active-low strobes; released strobes read high.
`timescale 1ns/10ps
module emic_sram_model (
  input wire clk,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  input wire [7:0] ad,
  input wire [7:0] hi,
  output logic drv_en,
  output logic [7:0] drv_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  // Latch takes the bus at each edge while the strobe is high; a transparent
  // latch would race the bus, which changes in the same step as the strobe falls
  always @(posedge clk) if (ale) lat <= ad;
  // Write data sampled while the write strobe is low
  always @(posedge clk) if (!wr_n) mem[{hi, lat}] <= ad;
  // Drive only during the read strobe, released otherwise
  assign drv_en = !rd_n;
  assign drv_data = mem[{hi, lat}];
endmodule

/* emic_testbench.sv */
// Testbench for the memory interface controller.
// Assumes emic_ctrl, the SRAM model and the checker compiled first.
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, cpu_req = 1'h0, cpu_we = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [15:0] cpu_addr = 16'h0;
  logic [7:0] cpu_wdata = 8'h0, pval = 8'h0, pdir = 8'h0, ad_last = 8'h0;
  wire [31:0] avs_readdata;
  wire [1:0] avs_response;
  wire avs_waitrequest, cpu_done, cpu_internal, ale_out, ale_oe_n, rd_n_out, rd_oe_n;
  wire wr_n_out, wr_oe_n, keeper_active, m_en;
  wire [7:0] cpu_rdata, ad_out, ad_oe_n, hi_out, hi_oe_n, keeper_level, m_dat, ad_pin, ad_rest;
  int err_count = 0, n_checks = 0, cyc = 0, k;
  always #4 clk_sys = ~clk_sys;
  // Pin level: design, else memory, else keeper, else changing junk
  assign ad_rest = m_en ? m_dat : (keeper_active ? keeper_level : ~ad_last);
  assign ad_pin = (~ad_oe_n & ad_out) | (ad_oe_n & ad_rest);
  always @(posedge clk_sys) ad_last <= ad_pin;
  emic_ctrl u_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_response, .cpu_req, .cpu_we,
    .cpu_addr, .cpu_wdata, .cpu_done, .cpu_rdata, .cpu_internal, .port_ad_out(pval),
    .port_ad_dir(pdir), .port_hi_out(pval), .port_hi_dir(pdir), .port_ale_out(1'h0),
    .port_ale_dir(pdir[0]), .port_rd_out(1'h1), .port_rd_dir(pdir[1]), .port_wr_out(1'h1),
    .port_wr_dir(pdir[2]), .muxed_addr_data_bus_in(ad_pin), .muxed_addr_data_bus_out(ad_out),
    .muxed_addr_data_bus_oe_n(ad_oe_n), .high_address_bus_out(hi_out), .high_address_bus_oe_n(hi_oe_n),
    .ale_out, .ale_oe_n, .rd_n_out, .rd_oe_n, .wr_n_out, .wr_oe_n, .keeper_level, .keeper_active);
  // A 32KB part: its top address line is left open
  emic_sram_model u_mem (.clk(clk_sys), .ale(ale_out & !ale_oe_n), .rd_n(rd_n_out | rd_oe_n),
    .wr_n(wr_n_out | wr_oe_n), .ad(ad_pin), .hi(hi_out & 8'h7F), .drv_en(m_en), .drv_data(m_dat));
  // ======
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task av(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e, input logic [1:0] r);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    if (!wr) chk(avs_readdata, {24'h0, e});
    if (!wr) chk({30'h0, avs_response}, {30'h0, r});
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task acc(input logic we, input logic [15:0] a, input logic [7:0] d, input int ne, input logic ie);
    int n;
    n = 0;
    @(posedge clk_sys);
    cpu_req <= 1'h1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cpu_done !== 1'h1);
    cpu_req <= 1'h0;
    chk(n, ne);
    chk({31'h0, cpu_internal}, {31'h0, ie});
    if (!we && !ie) chk({24'h0, cpu_rdata}, {24'h0, d});
  endtask
  // ======
  // Scenarios
  task t_regs;
    av(1'h0, 4'h0, 8'h0, 8'h00, 2'h0);
    av(1'h1, 4'h4, 8'hFF, 8'h0, 2'h0);
    av(1'h0, 4'h4, 8'h0, 8'h87, 2'h0);
    av(1'h0, 4'hC, 8'h0, 8'h00, 2'h2);
  endtask
  task t_off;
    av(1'h1, 4'h4, 8'h00, 8'h0, 2'h0);
    pdir <= 8'hA5;
    acc(1'h0, 16'h2000, 8'h0, 3, 1'h1);
    chk({24'h0, hi_oe_n}, {24'h0, ~pdir});
    pdir <= 8'h00;
  endtask
  task t_sect;
    av(1'h1, 4'h0, 8'hA6, 8'h0, 2'h0);
    acc(1'h1, 16'h3FFF, 8'h3C, 6, 1'h0);
    acc(1'h0, 16'h3FFF, 8'h3C, 6, 1'h0);
    acc(1'h1, 16'h4000, 8'hC3, 5, 1'h0);
    acc(1'h0, 16'h4000, 8'hC3, 5, 1'h0);
    acc(1'h0, 16'h1000, 8'h0, 3, 1'h1);
    chk({31'h0, ale_oe_n}, 32'h0);
    av(1'h1, 4'h0, 8'h8C, 8'h0, 2'h0);
    acc(1'h1, 16'h1100, 8'h5A, 6, 1'h0);
    acc(1'h0, 16'h1100, 8'h5A, 6, 1'h0);
    acc(1'h1, 16'h8001, 8'h96, 6, 1'h0);
    chk({24'h0, u_mem.mem[16'h0001]}, {24'h0, 8'h96});
    acc(1'h0, 16'h8001, 8'h96, 6, 1'h0);
  endtask
  task t_mask;
    pval <= 8'hA5;
    for (k = 0; k < 8; k++) begin
      av(1'h1, 4'h4, k[7:0], 8'h0, 2'h0);
      @(posedge clk_sys);
      chk({24'h0, hi_oe_n}, {24'h0, (k == 7) ? 8'hFF : ~(8'hFF >> k)});
      chk({24'h0, hi_out & ~(8'hFF >> k)}, {24'h0, pval & ~(8'hFF >> k)});
    end
  endtask
  task t_keep;
    av(1'h1, 4'h0, 8'h00, 8'h0, 2'h0);
    av(1'h1, 4'h4, 8'h80, 8'h0, 2'h0);
    @(posedge clk_sys);
    chk({31'h0, keeper_active}, 32'h1);
    pdir <= 8'hFF;
    repeat (2) @(posedge clk_sys);
    pdir <= 8'h00;
    repeat (3) @(posedge clk_sys);
    chk({24'h0, ad_pin}, {24'h0, 8'hA5});
    av(1'h0, 4'h8, 8'h0, 8'hA5, 2'h0);
    av(1'h1, 4'h4, 8'h00, 8'h0, 2'h0);
    @(posedge clk_sys);
    chk({31'h0, keeper_active}, 32'h0);
  endtask
  task print_verdict;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    t_regs();
    t_off();
    t_sect();
    t_mask();
    t_keep();
    print_verdict();
  end
endmodule
bind emic_ctrl emic_ctrl_checker #(.ISRAM_END(ISRAM_END)) u_chk (.clk_sys, .rst, .avs_address, .avs_read,
  .avs_readdata, .avs_waitrequest, .avs_response, .cpu_req, .cpu_addr, .cpu_done, .cpu_internal,
  .muxed_addr_data_bus_out, .ale_out, .ale_oe_n, .rd_n_out, .rd_oe_n, .wr_n_out, .wr_oe_n);
